/* logic/btd_pkg.sv */
// Package: descriptor field positions, encodings and reset values
package btd_pkg;
   // ======================================================
   // Second-word fields (bit positions within 64-bit word 1)
   localparam int SPLIT_BIT      = 46;
   localparam int TYPE_HI        = 45;
   localparam int TYPE_LO        = 44;
   localparam int TOKEN_HI       = 43;
   localparam int TOKEN_LO       = 42;
   localparam int FUNC_HI        = 41;
   localparam int FUNC_LO        = 35;
   localparam int EPHI_HI        = 34;
   localparam int EPHI_LO        = 32;
   localparam int RSVD1_HI       = 63;
   localparam int RSVD1_LO       = 47;
   // ======================================================
   // First-word fields (bit positions within 64-bit word 0)
   localparam int EPLO_BIT       = 31;
   localparam int MULT_HI        = 30;
   localparam int MULT_LO        = 29;
   localparam int PKT_HI         = 28;
   localparam int PKT_LO         = 18;
   localparam int TOTAL_HI       = 17;
   localparam int TOTAL_LO       = 3;
   localparam int ACTIVE_BIT     = 0;
   // ======================================================
   // Encodings
   localparam logic [1:0] TYPE_CONTROL = 2'h0;
   localparam logic [1:0] TYPE_BULK    = 2'h2;
   localparam logic [1:0] TOK_OUT      = 2'h0;
   localparam logic [1:0] TOK_IN       = 2'h1;
   localparam logic [1:0] TOK_SETUP    = 2'h2;
   localparam logic [1:0] TOK_PING     = 2'h3;
   localparam logic [1:0] MULT_UNDEF   = 2'h0;
   localparam logic [10:0] BULK_PKT_MAX = 11'h200;
   localparam logic [3:0] NAK_RST      = 4'h0;
endpackage : btd_pkg

/* logic/btd_nak_ctr.sv */
// NAK retry counter with reload and expiry detection
`timescale 1ns/1ps
module btd_nak_ctr #(
   parameter int W = 4
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] load_value,
   input  wire logic [W-1:0] nak_reload_value,
   input  wire logic         xact_ack,
   input  wire logic         xact_nak,
   output logic [W-1:0]      nak_retry_count,
   output logic              expired
);
   logic [W-1:0] cnt_q, cnt_d;
   logic         exp_q, exp_d;

   // ======================================================
   // Next count: load, reload on ACK, decrement on NAK
   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (load) begin
         cnt_d = load_value;
      end else if (xact_ack) begin
         cnt_d = nak_reload_value;
      end else if (xact_nak && nak_reload_value != '0 && cnt_q != '0) begin
         cnt_d = cnt_q - W'(1);
         exp_d = (cnt_q == W'(1));
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign nak_retry_count = cnt_q;
   assign expired         = exp_q;
endmodule : btd_nak_ctr

/* logic/btd_decode.sv */
// Bulk/control transfer descriptor decoder and active-flag keeper
//
// What this block does
// - Bit 46 split; bits 45:44 type
// - Token from bits 43:42 of word one
// - PING code placed only by hardware; a loaded PING is kept and flagged bad
// - Bits 41:35 give target function number
// - Endpoint: 34:32 upper, bit 31 low
// - Bits 30:29 give successive packet count
// - Bits 28:18 cap each data packet
// - Bits 17:3 give fifteen-bit byte total
// - Clear active on completion or fatal error
// - NAK expiry clears active; ACK reloads
`timescale 1ns/1ps
module btd_decode #(
   parameter int NAK_W = 4
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             load,
   input  wire logic [63:0]      desc_word0,
   input  wire logic [63:0]      desc_word1,
   input  wire logic [NAK_W-1:0] nak_reload_value,
   input  wire logic [NAK_W-1:0] nak_start_value,
   input  wire logic             ping_enter,
   input  wire logic             ping_leave,
   input  wire logic             xact_ack,
   input  wire logic             xact_nak,
   input  wire logic             xact_done,
   input  wire logic             fatal_error,
   output logic                  split_select,
   output logic [1:0]            transfer_type_code,
   output logic [1:0]            token_code,
   output logic [6:0]            target_function_number,
   output logic [3:0]            target_endpoint_number,
   output logic [1:0]            packet_multiplier,
   output logic [10:0]           packet_size_limit,
   output logic [14:0]           transfer_byte_total,
   output logic                  active_flag,
   output logic [NAK_W-1:0]      nak_retry_count,
   output logic                  bad_descriptor
);
   // ======================================================
   // Decoded field registers and their next values
   logic             split_q;
   logic             split_d;
   logic [1:0]       type_q;
   logic [1:0]       type_d;
   logic [1:0]       tok_q;
   logic [1:0]       tok_d;
   logic [6:0]       func_q;
   logic [6:0]       func_d;
   logic [3:0]       ep_q;
   logic [3:0]       ep_d;
   logic [1:0]       mult_q;
   logic [1:0]       mult_d;
   logic [10:0]      pkt_q;
   logic [10:0]      pkt_d;
   logic [14:0]      total_q;
   logic [14:0]      total_d;
   logic             bad_q;
   logic             bad_d;
   // Active flag and what the NAK counter reports
   logic             act_q;
   logic             act_d;
   logic             clear_req;
   logic [NAK_W-1:0] nak_cnt;
   logic             nak_expired;
   logic             ack_live;
   logic             nak_live;
   // Raw slices of the two words, ahead of any register
   logic             raw_split;
   logic [1:0]       raw_type;
   logic [1:0]       raw_tok;
   logic [6:0]       raw_func;
   logic [3:0]       raw_ep;
   logic [1:0]       raw_mult;
   logic [10:0]      raw_pkt;
   logic [14:0]      raw_total;
   logic             raw_active;
   // Software slips, one term per rule that software must keep
   logic             slip_ping;
   logic             slip_mult;
   logic             slip_size;
   logic             slip_rsvd;

   // ======================================================
   // Field slices: plain wiring, so a load costs no extra cycle
   assign raw_split =
      desc_word1[btd_pkg::SPLIT_BIT];
   assign raw_type =
      desc_word1[btd_pkg::TYPE_HI:btd_pkg::TYPE_LO];
   assign raw_tok =
      desc_word1[btd_pkg::TOKEN_HI:btd_pkg::TOKEN_LO];
   assign raw_func =
      desc_word1[btd_pkg::FUNC_HI:btd_pkg::FUNC_LO];
   assign raw_ep =
      {desc_word1[btd_pkg::EPHI_HI:btd_pkg::EPHI_LO],
       desc_word0[btd_pkg::EPLO_BIT]};
   assign raw_mult =
      desc_word0[btd_pkg::MULT_HI:btd_pkg::MULT_LO];
   assign raw_pkt =
      desc_word0[btd_pkg::PKT_HI:btd_pkg::PKT_LO];
   assign raw_total =
      desc_word0[btd_pkg::TOTAL_HI:btd_pkg::TOTAL_LO];
   assign raw_active =
      desc_word0[btd_pkg::ACTIVE_BIT];

   // Slips are only flagged; decoding still goes on as written,
   // since the engine may need the fields to report the fault
   assign slip_ping = (raw_tok == btd_pkg::TOK_PING);
   assign slip_mult = (raw_mult == btd_pkg::MULT_UNDEF);
   assign slip_size = (raw_type == btd_pkg::TYPE_BULK)
                    && (raw_pkt > btd_pkg::BULK_PKT_MAX);
   assign slip_rsvd =
      |desc_word1[btd_pkg::RSVD1_HI:btd_pkg::RSVD1_LO];

   // ======================================================
   // Field next values: a load takes the words; between loads
   // only the token moves, and only between OUT and PING
   always_comb begin
      split_d = split_q;
      type_d  = type_q;
      tok_d   = tok_q;
      func_d  = func_q;
      ep_d    = ep_q;
      mult_d  = mult_q;
      pkt_d   = pkt_q;
      total_d = total_q;
      bad_d   = bad_q;
      if (load) begin
         split_d = raw_split;
         type_d  = raw_type;
         tok_d   = raw_tok;
         func_d  = raw_func;
         ep_d    = raw_ep;
         mult_d  = raw_mult;
         pkt_d   = raw_pkt;
         total_d = raw_total;
         bad_d   = slip_ping | slip_mult | slip_size | slip_rsvd;
      end else if (ping_enter && tok_q == btd_pkg::TOK_OUT) begin
         tok_d = btd_pkg::TOK_PING;   // Hardware writes PING here; a loaded PING is kept and flagged
      end else if (ping_leave && tok_q == btd_pkg::TOK_PING) begin
         tok_d = btd_pkg::TOK_OUT;
      end
   end

   // Field registers; reset leaves an idle control OUT descriptor
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         split_q <= 1'b0;
         type_q  <= btd_pkg::TYPE_CONTROL;
         tok_q   <= btd_pkg::TOK_OUT;
         func_q  <= 7'h00;
         ep_q    <= 4'h0;
         mult_q  <= 2'h0;
         pkt_q   <= 11'h000;
         total_q <= 15'h0000;
         bad_q   <= 1'b0;
      end else begin
         split_q <= split_d;
         type_q  <= type_d;
         tok_q   <= tok_d;
         func_q  <= func_d;
         ep_q    <= ep_d;
         mult_q  <= mult_d;
         pkt_q   <= pkt_d;
         total_q <= total_d;
         bad_q   <= bad_d;
      end
   end

   // ======================================================
   // Active flag: software sets it through a load, hardware only
   // clears it. A load wins over a same-cycle clear, so the tail
   // of the old descriptor never drops a fresh one.
   assign clear_req = xact_done | fatal_error;

   always_comb begin
      act_d = act_q;
      if (load) begin
         act_d = raw_active;
      end else if (clear_req) begin
         act_d = 1'b0;
      end else if (nak_expired) begin
         act_d = 1'b0;
      end
   end

   // Active flag register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         act_q <= 1'b0;
      end else begin
         act_q <= act_d;
      end
   end

   // ======================================================
   // NAK retry counter. Handshake results count only while the
   // descriptor is live, so a stale ACK cannot revive the count.
   assign ack_live = xact_ack & act_q;
   assign nak_live = xact_nak & act_q;

   btd_nak_ctr #(.W(NAK_W)) u_nak (
      .clock            (clock),
      .rst_n            (rst_n),
      .load             (load),
      .load_value       (nak_start_value),
      .nak_reload_value (nak_reload_value),
      .xact_ack         (ack_live),
      .xact_nak         (nak_live),
      .nak_retry_count  (nak_cnt),
      .expired          (nak_expired)
   );

   // Outputs straight from flip-flops
   assign split_select           = split_q;
   assign transfer_type_code     = type_q;
   assign token_code             = tok_q;
   assign target_function_number = func_q;
   assign target_endpoint_number = ep_q;
   assign packet_multiplier      = mult_q;
   assign packet_size_limit      = pkt_q;
   assign transfer_byte_total    = total_q;
   assign active_flag            = act_q;
   assign nak_retry_count        = nak_cnt;
   assign bad_descriptor         = bad_q;
endmodule : btd_decode

/* testbench/btd_sw_model.sv */
// Software side model: legal descriptors built from raw words
`timescale 1ns/1ps
module btd_sw_model (
   input  wire logic [63:0] raw0,
   input  wire logic [63:0] raw1,
   output logic      [63:0] word0,
   output logic      [63:0] word1
);
   // =============================================
   // Legalise fields before software hands them on
   always_comb begin
      word0 = raw0;
      word1 = {17'h00000, raw1[46:0]};
      word1[44] = 1'b0;
      if (raw1[43:42] == 2'h3)
         word1[43:42] = 2'h0;
      if (raw0[30:29] == 2'h0)
         word0[30:29] = 2'h1;
      if (word1[45:44] == 2'h2 && raw0[28:18] > 11'h200)
         word0[28:18] = 11'h200;
      word0[0] = raw0[17:3] != 15'h0000;
   end
endmodule : btd_sw_model

/* testbench/btd_decode_assertions.sv */
// Port checker for the descriptor decoder
`timescale 1ns/1ps
module btd_decode_assertions #(
   parameter int NAK_W = 4
) (
   input wire logic clock, rst_n, load, ping_enter,
   input wire logic xact_ack, xact_nak, xact_done, fatal_error,
   input wire logic [63:0] desc_word0, desc_word1,
   input wire logic [NAK_W-1:0] nak_reload_value, nak_retry_count,
   input wire logic split_select, active_flag, bad_descriptor,
   input wire logic [1:0] transfer_type_code, token_code,
   input wire logic [1:0] packet_multiplier,
   input wire logic [6:0] target_function_number,
   input wire logic [3:0] target_endpoint_number,
   input wire logic [10:0] packet_size_limit,
   input wire logic [14:0] transfer_byte_total
);
   // =============================================
   // One clock domain, reset disables everything
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Last countable NAK, then a quiet cycle
   sequence s_last_nak;
      xact_nak && !xact_ack && !load && active_flag
      && nak_retry_count == NAK_W'(1) && nak_reload_value != '0;
   endsequence
   sequence s_quiet;
      !load && !xact_ack && nak_reload_value != '0;
   endsequence
   a_word1_fields: assert property (load |=>
      {split_select, transfer_type_code, token_code, target_function_number}
      == $past(desc_word1[46:35])) else $error("word1 fields");
   a_endpoint_pair: assert property (load |=>
      target_endpoint_number
      == {$past(desc_word1[34:32]), $past(desc_word0[31])})
      else $error("endpoint");
   a_word0_fields: assert property (load |=>
      {packet_multiplier, packet_size_limit, transfer_byte_total}
      == $past(desc_word0[30:3])) else $error("word0 fields");
   a_active_load: assert property (load |=>
      active_flag == $past(desc_word0[0])) else $error("active load");
   a_active_clear: assert property ((xact_done || fatal_error)
      && !load |=> !active_flag) else $error("active clear");
   a_nak_expiry: assert property (s_last_nak ##1 s_quiet
      |=> !active_flag) else $error("nak expiry");
   a_ack_reload: assert property (xact_ack && active_flag && !load
      |=> nak_retry_count == $past(nak_reload_value)) else $error("reload");
   a_nak_ignored: assert property (xact_nak && !xact_ack && !load
      && nak_reload_value == '0
      |=> nak_retry_count == $past(nak_retry_count))
      else $error("nak without reload");
   a_ping_entry: assert property (ping_enter && !load
      && token_code == 2'h0 |=> token_code == 2'h3) else $error("ping");
   a_bad_mult: assert property (load && desc_word0[30:29] == 2'h0
      |=> bad_descriptor) else $error("bad flag");
endmodule : btd_decode_assertions
bind btd_decode btd_decode_assertions #(.NAK_W(NAK_W)) u_chk (
   .clock                  (clock),
   .rst_n                  (rst_n),
   .load                   (load),
   .ping_enter             (ping_enter),
   .xact_ack               (xact_ack),
   .xact_nak               (xact_nak),
   .xact_done              (xact_done),
   .fatal_error            (fatal_error),
   .desc_word0             (desc_word0),
   .desc_word1             (desc_word1),
   .nak_reload_value       (nak_reload_value),
   .nak_retry_count        (nak_retry_count),
   .split_select           (split_select),
   .active_flag            (active_flag),
   .bad_descriptor         (bad_descriptor),
   .transfer_type_code     (transfer_type_code),
   .token_code             (token_code),
   .packet_multiplier      (packet_multiplier),
   .target_function_number (target_function_number),
   .target_endpoint_number (target_endpoint_number),
   .packet_size_limit      (packet_size_limit),
   .transfer_byte_total    (transfer_byte_total)
);

/* testbench/tb_top.sv */
// Self-checking bench for the descriptor decoder
`timescale 1ns/1ps
module tb_top;
   logic        clock, rst_n, load;
   logic [63:0] raw0, raw1, d0, d1, w0, w1, a, b;
   logic [3:0]  reload, start, st;
   logic [5:0]  p;
   logic [49:0] got, e, n, exp_q[$];
   int          failures, checks_done;
   event        ev;
   btd_sw_model u_sw (.raw0(raw0), .raw1(raw1), .word0(w0), .word1(w1));
   btd_decode #(.NAK_W(4)) u_dut (
      .clock(clock), .rst_n(rst_n), .load(load), .desc_word0(d0),
      .desc_word1(d1), .nak_reload_value(reload), .nak_start_value(start),
      .ping_enter(p[5]), .ping_leave(p[4]), .xact_ack(p[3]),
      .xact_nak(p[2]), .xact_done(p[1]), .fatal_error(p[0]),
      .split_select(got[49]), .transfer_type_code(got[48:47]),
      .token_code(got[46:45]), .target_function_number(got[44:38]),
      .target_endpoint_number(got[37:34]), .packet_multiplier(got[33:32]),
      .packet_size_limit(got[31:21]), .transfer_byte_total(got[20:6]),
      .active_flag(got[5]), .nak_retry_count(got[4:1]),
      .bad_descriptor(got[0]));
   // =============================================
   // Clock, and a hang guard
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #100000 failures++;
      finish_test();
   end
   // Oldest note against the settled outputs
   initial forever begin
      @(ev);
      n = exp_q.pop_front();
      checks_done++;
      if (got !== n) begin
         failures++;
         $display("[ERR] outputs exp %h got %h", n, got);
      end
   end
   function automatic logic [49:0] dec(input logic [63:0] x, y,
                                       input logic [3:0] s);
      logic bad;
      bad = y[43:42] == 2'h3 || x[30:29] == 2'h0 || y[63:47] != 17'h00000
         || (y[45:44] == btd_pkg::TYPE_BULK
         && x[28:18] > btd_pkg::BULK_PKT_MAX);
      return {y[46:32], x[31:3], x[0], s, bad};
   endfunction : dec
   // One cycle of strobes, then note the outcome
   task automatic step(input logic l, input logic [5:0] pp,
                       input logic [49:0] ex);
      @(posedge clock);
      #1 load = l;
      p = pp;
      d0 = a;
      d1 = b;
      start = st;
      @(posedge clock);
      #1 load = 1'b0;
      p = 6'h00;
      exp_q.push_back(ex);
      e = ex;
      -> ev;
   endtask : step
   task automatic ld(input logic [3:0] s, input logic [5:0] pp);
      st = s;
      step(1'b1, pp, dec(a, b, s));
   endtask : ld
   task automatic finish_test();
      #2 $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   initial begin
      {load, p, d0, d1, raw0, raw1, start, reload} = '0;
      {failures, checks_done, rst_n} = '0;
      void'($urandom(10));
      repeat (5) @(posedge clock);
      #1 rst_n = 1'b1;
      // All outputs still at their reset values after the first edge
      @(posedge clock);
      #1 exp_q.push_back(50'h0);
      -> ev;
      for (int i = 0; i < 9; i++) begin
         raw0 = {$urandom, $urandom};
         raw1 = {$urandom, $urandom};
         raw1[43:42] = 2'(i % 3);
         #1 {a, b} = {w0, w1};
         ld(4'(i), 6'h00);
      end
      // Each fault software must never write is flagged
      for (int i = 0; i < 4; i++) begin
         {a, b} = {w0, w1};
         if (i == 0) b[43:42] = 2'h3;
         if (i == 1) a[30:29] = 2'h0;
         if (i == 2) {b[45:44], a[28:18]} = {2'h2, 11'h201};
         if (i == 3) b[63] = 1'b1;
         ld(4'h0, 6'h00);
      end
      // Live OUT descriptor: PING in and out, then NAK expiry
      {a, b} = {w0 | 64'h1, w1 & ~64'h00000C0000000000};
      reload = 4'h3;
      ld(4'h1, 6'h00);
      e[46:45] = 2'h3;
      step(1'b0, 6'h20, e);
      e[46:45] = 2'h0;
      step(1'b0, 6'h10, e);
      e[4:1] = 4'h0;
      step(1'b0, 6'h04, e);
      e[5] = 1'b0;
      step(1'b0, 6'h08, e);
      ld(4'h1, 6'h00);
      e[4:1] = reload;
      step(1'b0, 6'h08, e);
      e[5] = 1'b0;
      step(1'b0, 6'h02, e);
      ld(4'h2, 6'h00);
      e[5] = 1'b0;
      step(1'b0, 6'h01, e);
      ld(4'h2, 6'h02);
      // With no reload value a NAK leaves count and flag alone
      reload = 4'h0;
      step(1'b0, 6'h04, e);
      // Mid-run reset clears everything; a load works right after
      @(posedge clock);
      #1 rst_n = 1'b0;
      @(posedge clock);
      #1 rst_n = 1'b1;
      @(posedge clock);
      #1 exp_q.push_back(50'h0);
      -> ev;
      ld(4'h3, 6'h00);
      finish_test();
   end
endmodule : tb_top
